// [design/bbr_pkg.sv]
// constants and register layout for the bridge bus-number and io-window register bank
//
// Contract
// RULE_01: primary tenure register, bits 15:8, read-write, reset zero, loads primary master timer.
// RULE_02: layout-kind field, bits 23:16, read-only, always reads 01h.
// RULE_03: upstream bus index, bits 7:0, read-write, reset zero, set by software.
// RULE_04: downstream bus index, bits 15:8, read-write, reset zero, set by software.
// RULE_05: highest bus index, bits 23:16, read-write, reset zero, set by software.
// RULE_06: secondary tenure register, bits 31:24, read-write, reset zero, clocks from secondary frame.
// RULE_07: secondary tenure zero and grant removed: end after first data phase, except MWI.
// RULE_08: io window low/high bytes, low nibbles read-only, return 1 for 32-bit io.
// RULE_09: io window low nibble bits 7:4, reset zero, gives bound bits 15:12; 11:0 zero.
// RULE_10: io window high nibble bits 15:12 gives bound bits 15:12; 11:0 all ones.
// RULE_11: io bounds steer forwarding; bits 31:16 come from separate upper-half registers.
// RULE_12: address inside window when lower bound <= address <= upper bound, 32-bit compare.
package bbr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  OFS_LAT_HDR   = 8'h0C;
  localparam logic [7:0]  OFS_BUS_NUM   = 8'h18;
  localparam logic [7:0]  OFS_IO_WIN    = 8'h1C;
  localparam logic [7:0]  OFS_IO_UPPER  = 8'h30;
  localparam logic [7:0]  OFS_STATUS    = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // field positions (low bit of each field)
  localparam int          POS_PRIM_LAT  = 8;
  localparam int          POS_LAYOUT    = 16;
  localparam int          POS_UP_BUS    = 0;
  localparam int          POS_DOWN_BUS  = 8;
  localparam int          POS_HIGH_BUS  = 16;
  localparam int          POS_SEC_LAT   = 24;
  localparam int          POS_IOLO_CAP  = 0;
  localparam int          POS_IOLO_NIB  = 4;
  localparam int          POS_IOHI_CAP  = 8;
  localparam int          POS_IOHI_NIB  = 12;
  localparam int          POS_IOLO_UP   = 0;
  localparam int          POS_IOHI_UP   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset and fixed values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [3:0]  RST_NIB       = 4'h0;
  localparam logic [15:0] RST_UPPER     = 16'h0000;
  localparam logic [7:0]  LAYOUT_KIND   = 8'h01;
  localparam logic [3:0]  IO_CAP_32     = 4'h1;
  localparam logic [11:0] IO_LOW_FILL   = 12'h000;
  localparam logic [11:0] IO_HIGH_FILL  = 12'hFFF;
  localparam logic [7:0]  TENURE_ZERO   = 8'h00;

endpackage : bbr_pkg

// [design/bbr_tenure_timer.sv]
// master tenure timer: loaded at frame assertion, counts pci clocks down to expiry
`timescale 1ns/1ps
module bbr_tenure_timer
  import bbr_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic [7:0] load_val,
  input  wire logic       frame_start,
  input  wire logic       master_active,
  // state
  output logic      [7:0] count_q,
  output logic            expired_q
);

  logic [7:0] count_d;
  logic       expired_d;
  wire        at_zero   = (count_q == TENURE_ZERO);
  wire        last_tick = (count_q == 8'h01);

  // a new frame always reloads, even if the last tenure never ended
  assign count_d   = frame_start ? load_val :
                     (master_active && !at_zero) ? count_q - 8'h01 : count_q;
  assign expired_d = frame_start ? (load_val == TENURE_ZERO) :
                     !master_active ? 1'b0 :
                     (expired_q || last_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= TENURE_ZERO;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

endmodule // bbr_tenure_timer

// [design/bbr_io_window.sv]
// io forwarding window hit check, registered
`timescale 1ns/1ps
module bbr_io_window
  import bbr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bounds
  input  wire logic [31:0] low_bound,
  input  wire logic [31:0] high_bound,
  // lookup
  input  wire logic        io_req_valid,
  input  wire logic [31:0] io_req_addr,
  output logic             io_hit_valid_q,
  output logic             io_hit_q
);

  // inclusive at both ends; an inverted window never hits
  wire in_window = (io_req_addr >= low_bound) && (io_req_addr <= high_bound); // [RULE_12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hit_valid_q <= 1'b0;
      io_hit_q       <= 1'b0;
    end else begin
      io_hit_valid_q <= io_req_valid;
      io_hit_q       <= io_req_valid && in_window;
    end
  end

endmodule // bbr_io_window

// [design/bbr_regs.sv]
// bridge bus-number, tenure and io-window register bank with apb slave and tenure control
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module bbr_regs
  import bbr_pkg::*;
(
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // primary master side
  input  wire logic              p_frame_start,
  input  wire logic              p_master_active,
  output logic                   p_tenure_expired,
  // secondary master side
  input  wire logic              s_frame_start,
  input  wire logic              s_master_active,
  input  wire logic              s_gnt_n,
  input  wire logic              s_cmd_mwi,
  input  wire logic              s_first_data_done,
  output logic                   s_tenure_expired,
  output logic                   s_end_now,
  // io forwarding lookup
  input  wire logic              io_req_valid,
  input  wire logic [31:0]       io_req_addr,
  output logic                   io_hit_valid,
  output logic                   io_fwd_hit,
  // bus numbers for the forwarding logic
  output logic [7:0]             up_bus_index,
  output logic [7:0]             down_bus_index,
  output logic [7:0]             highest_bus_index
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge one byte lane of a write under its strobe
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [DATA_W-1:0] wdata,
                                            input logic [3:0] strb, input int lane);
    logic [7:0] new_v;
    new_v = wdata[lane*8 +: 8];
    return strb[lane] ? new_v : old_v;
  endfunction

  // same for a writable upper nibble of a lane
  function automatic logic [3:0] nib_merge(input logic [3:0] old_v, input logic [DATA_W-1:0] wdata,
                                           input logic [3:0] strb, input int lane);
    logic [3:0] new_v;
    new_v = wdata[lane*8+4 +: 4];
    return strb[lane] ? new_v : old_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]        prim_lat_q;
  logic [7:0]        up_bus_q;
  logic [7:0]        down_bus_q;
  logic [7:0]        high_bus_q;
  logic [7:0]        sec_lat_q;
  logic [3:0]        io_lo_nib_q;
  logic [3:0]        io_hi_nib_q;
  logic [15:0]       io_lo_up_q;
  logic [15:0]       io_hi_up_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pslverr_q;
  logic              s_end_q;

  logic [7:0]        prim_lat_d;
  logic [7:0]        up_bus_d;
  logic [7:0]        down_bus_d;
  logic [7:0]        high_bus_d;
  logic [7:0]        sec_lat_d;
  logic [3:0]        io_lo_nib_d;
  logic [3:0]        io_hi_nib_d;
  logic [15:0]       io_lo_up_d;
  logic [15:0]       io_hi_up_d;
  logic              s_end_d;

  logic [7:0]        p_count;
  logic [7:0]        s_count;
  logic              p_expired;
  logic              s_expired;
  logic [31:0]       io_lo_bound;
  logic [31:0]       io_hi_bound;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // read data is fetched in the setup cycle so it can come from flops in the access cycle
  wire setup_phase  = psel && !penable;
  wire access_phase = psel && penable;

  wire hit_lat_hdr  = (paddr == OFS_LAT_HDR);
  wire hit_bus_num  = (paddr == OFS_BUS_NUM);
  wire hit_io_win   = (paddr == OFS_IO_WIN);
  wire hit_io_upper = (paddr == OFS_IO_UPPER);
  wire hit_status   = (paddr == OFS_STATUS);
  wire addr_mapped  = hit_lat_hdr || hit_bus_num || hit_io_win || hit_io_upper || hit_status;

  // status is read-only; a write there is refused like an unmapped one
  wire addr_bad     = !addr_mapped || (pwrite && hit_status);
  wire wr_ok        = access_phase && pwrite && !addr_bad;

  wire wr_lat_hdr   = wr_ok && hit_lat_hdr;
  wire wr_bus_num   = wr_ok && hit_bus_num;
  wire wr_io_win    = wr_ok && hit_io_win;
  wire wr_io_upper  = wr_ok && hit_io_upper;

  ////////////////////////////////////////////////////////////////////////////
  // read words

  wire [DATA_W-1:0] rd_lat_hdr;
  wire [DATA_W-1:0] rd_bus_num;
  wire [DATA_W-1:0] rd_io_win;
  wire [DATA_W-1:0] rd_io_upper;
  wire [DATA_W-1:0] rd_status;
  wire [DATA_W-1:0] rd_word;

  // cache line size and self-test bytes live elsewhere; they read as zero here
  assign rd_lat_hdr  = {8'h00, LAYOUT_KIND, prim_lat_q, 8'h00};         // [RULE_01] [RULE_02]
  assign rd_bus_num  = {sec_lat_q, high_bus_q, down_bus_q, up_bus_q};     // [RULE_03] [RULE_04] [RULE_05] [RULE_06]
  // upper half of this word is the secondary status block, not kept here
  assign rd_io_win   = {16'h0000, io_hi_nib_q, IO_CAP_32, io_lo_nib_q, IO_CAP_32}; // [RULE_08]
  assign rd_io_upper = {io_hi_up_q, io_lo_up_q};
  assign rd_status   = {20'h00000, s_end_q, s_expired, p_expired, (io_lo_bound <= io_hi_bound), s_count};

  assign rd_word     = hit_lat_hdr  ? rd_lat_hdr  :
                       hit_bus_num  ? rd_bus_num  :
                       hit_io_win   ? rd_io_win   :
                       hit_io_upper ? rd_io_upper :
                       hit_status   ? rd_status   : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // next register values

  assign prim_lat_d  = wr_lat_hdr  ? lane_merge(prim_lat_q, pwdata, pstrb, 1) : prim_lat_q;  // [RULE_01]
  assign up_bus_d    = wr_bus_num  ? lane_merge(up_bus_q, pwdata, pstrb, 0)   : up_bus_q;    // [RULE_03]
  assign down_bus_d  = wr_bus_num  ? lane_merge(down_bus_q, pwdata, pstrb, 1) : down_bus_q;  // [RULE_04]
  assign high_bus_d  = wr_bus_num  ? lane_merge(high_bus_q, pwdata, pstrb, 2) : high_bus_q;  // [RULE_05]
  assign sec_lat_d   = wr_bus_num  ? lane_merge(sec_lat_q, pwdata, pstrb, 3)  : sec_lat_q;   // [RULE_06]
  // the capability nibbles are never stored, so a write to them has no effect
  assign io_lo_nib_d = wr_io_win   ? nib_merge(io_lo_nib_q, pwdata, pstrb, 0) : io_lo_nib_q; // [RULE_09]
  assign io_hi_nib_d = wr_io_win   ? nib_merge(io_hi_nib_q, pwdata, pstrb, 1) : io_hi_nib_q; // [RULE_10]
  assign io_lo_up_d  = wr_io_upper ? {lane_merge(io_lo_up_q[15:8], pwdata, pstrb, 1),
                                      lane_merge(io_lo_up_q[7:0], pwdata, pstrb, 0)} : io_lo_up_q;
  assign io_hi_up_d  = wr_io_upper ? {lane_merge(io_hi_up_q[15:8], pwdata, pstrb, 3),
                                      lane_merge(io_hi_up_q[7:0], pwdata, pstrb, 2)} : io_hi_up_q;

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_lat_q  <= RST_BYTE;
      up_bus_q    <= RST_BYTE;
      down_bus_q  <= RST_BYTE;
      high_bus_q  <= RST_BYTE;
      sec_lat_q   <= RST_BYTE;
      io_lo_nib_q <= RST_NIB;
      io_hi_nib_q <= RST_NIB;
      io_lo_up_q  <= RST_UPPER;
      io_hi_up_q  <= RST_UPPER;
    end else begin
      prim_lat_q  <= prim_lat_d;
      up_bus_q    <= up_bus_d;
      down_bus_q  <= down_bus_d;
      high_bus_q  <= high_bus_d;
      sec_lat_q   <= sec_lat_d;
      io_lo_nib_q <= io_lo_nib_d;
      io_hi_nib_q <= io_hi_nib_d;
      io_lo_up_q  <= io_lo_up_d;
      io_hi_up_q  <= io_hi_up_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, data and error captured in setup

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_word;
      pslverr_q <= addr_bad;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access_phase && pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // master tenure timers

  bbr_tenure_timer u_prim_timer (
    .pclk          (pclk),
    .presetn       (presetn),
    .load_val      (prim_lat_q),
    .frame_start   (p_frame_start),
    .master_active (p_master_active),
    .count_q       (p_count),
    .expired_q     (p_expired)
  ); // [RULE_01]

  bbr_tenure_timer u_sec_timer (
    .pclk          (pclk),
    .presetn       (presetn),
    .load_val      (sec_lat_q),
    .frame_start   (s_frame_start),
    .master_active (s_master_active),
    .count_q       (s_count),
    .expired_q     (s_expired)
  ); // [RULE_06]

  ////////////////////////////////////////////////////////////////////////////
  // secondary early termination

  // zero tenure plus lost grant: stop once the first data phase is done; mwi keeps its line
  assign s_end_d = s_master_active && !s_frame_start && (sec_lat_q == TENURE_ZERO) &&
                   s_gnt_n && !s_cmd_mwi && s_first_data_done; // [RULE_07]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_end_q <= 1'b0;
    end else begin
      s_end_q <= s_end_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // io forwarding window

  assign io_lo_bound = {io_lo_up_q, io_lo_nib_q, IO_LOW_FILL};  // [RULE_09] [RULE_11]
  assign io_hi_bound = {io_hi_up_q, io_hi_nib_q, IO_HIGH_FILL}; // [RULE_10] [RULE_11]

  bbr_io_window u_io_window (
    .pclk           (pclk),
    .presetn        (presetn),
    .low_bound      (io_lo_bound),
    .high_bound     (io_hi_bound),
    .io_req_valid   (io_req_valid),
    .io_req_addr    (io_req_addr),
    .io_hit_valid_q (io_hit_valid),
    .io_hit_q       (io_fwd_hit)
  ); // [RULE_11] [RULE_12]

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign p_tenure_expired  = p_expired;
  assign s_tenure_expired  = s_expired;
  assign s_end_now         = s_end_q;
  assign up_bus_index      = up_bus_q;
  assign down_bus_index    = down_bus_q;
  assign highest_bus_index = high_bus_q;

endmodule // bbr_regs

// [verif/bbr_regs_checker.sv]
// concurrent checks on the bus-number, tenure and io-window bank
`timescale 1ns/1ps
module bbr_regs_checker
  import bbr_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  // tenure
  input wire logic              p_frame_start,
  input wire logic              p_master_active,
  input wire logic              p_tenure_expired,
  input wire logic              s_frame_start,
  input wire logic              s_master_active,
  input wire logic              s_gnt_n,
  input wire logic              s_cmd_mwi,
  input wire logic              s_first_data_done,
  input wire logic              s_tenure_expired,
  input wire logic              s_end_now,
  // io and bus numbers
  input wire logic              io_req_valid,
  input wire logic              io_hit_valid,
  input wire logic [7:0]        up_bus_index
);
  logic [7:0] pri_ten_q;
  logic [7:0] sec_ten_q;
  wire        wr_acc = psel && penable && pwrite && pready;
  wire        rd_acc = psel && penable && !pwrite;
  // shadow copies: the bank's own flops are out of sight here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_ten_q <= RST_BYTE;
      sec_ten_q <= RST_BYTE;
    end else if (wr_acc) begin
      if (paddr == OFS_LAT_HDR && pstrb[1]) pri_ten_q <= pwdata[15:8];
      if (paddr == OFS_BUS_NUM && pstrb[3]) sec_ten_q <= pwdata[31:24];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pri_load;
    p_frame_start && p_master_active && pri_ten_q == 8'h01 ##1 p_master_active && !p_frame_start;
  endsequence
  sequence s_sec_load;
    s_frame_start && s_master_active && sec_ten_q == 8'h02 ##1 (s_master_active && !s_frame_start) [*2];
  endsequence
  property p_layout;
    rd_acc && paddr == OFS_LAT_HDR |-> prdata[23:16] == LAYOUT_KIND;
  endproperty
  a_layout: assert property (p_layout) else $error("layout kind not 01");
  property p_cap;
    rd_acc && paddr == OFS_IO_WIN |-> prdata[3:0] == IO_CAP_32 && prdata[11:8] == IO_CAP_32;
  endproperty
  a_cap: assert property (p_cap) else $error("io width nibble wrong");
  property p_hitv;
    io_req_valid |=> io_hit_valid;
  endproperty
  a_hitv: assert property (p_hitv) else $error("io lookup gave no answer");
  property p_up;
    wr_acc && paddr == OFS_BUS_NUM && pstrb[0] |-> ##2 up_bus_index == $past(pwdata[7:0], 2);
  endproperty
  a_up: assert property (p_up) else $error("upstream index not updated");
  property p_end;
    s_master_active && !s_frame_start && sec_ten_q == TENURE_ZERO && s_gnt_n && !s_cmd_mwi
      && s_first_data_done |=> s_end_now;
  endproperty
  a_end: assert property (p_end) else $error("end request missing");
  property p_mwi;
    s_cmd_mwi |=> !s_end_now;
  endproperty
  a_mwi: assert property (p_mwi) else $error("end request during mwi");
  property p_sexp;
    s_sec_load |-> !s_tenure_expired ##1 s_tenure_expired;
  endproperty
  a_sexp: assert property (p_sexp) else $error("secondary expiry mistimed");
  property p_pexp;
    s_pri_load |-> !p_tenure_expired ##1 p_tenure_expired;
  endproperty
  a_pexp: assert property (p_pexp) else $error("primary expiry mistimed");
endmodule // bbr_regs_checker

bind bbr_regs bbr_regs_checker i_bbr_regs_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .p_frame_start, .p_master_active, .p_tenure_expired, .s_frame_start, .s_master_active,
  .s_gnt_n, .s_cmd_mwi, .s_first_data_done, .s_tenure_expired, .s_end_now,
  .io_req_valid, .io_hit_valid, .up_bus_index
);

// [verif/bbr_host_model.sv]
// apb master model standing in for the configuring host
`timescale 1ns/1ps
module bbr_host_model
  import bbr_pkg::*;
(
  // clock
  input  wire logic              pclk,
  // apb request
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [DATA_W-1:0] pwdata,
  output logic      [3:0]        pstrb,
  // apb answer
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  // transfer report
  output logic                   rd_done,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_err,
  output logic                   to_seen
);
  initial begin
    {psel, penable, pwrite, rd_done, rd_err, to_seen} = 6'h00;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    rd_data = '0;
  end
  // entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) to_seen <= 1'b1;
    rd_done <= 1'b1;
    rd_data <= prdata;
    rd_err <= pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released address and data lines flip so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
    rd_done <= 1'b0;
  endtask
endmodule // bbr_host_model

// [verif/tb.sv]
// self-checking bench for the bus-number, tenure and io-window bank
`timescale 1ns/1ps
module tb
  import bbr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic p_frame_start, p_master_active, s_frame_start, s_master_active;
  logic s_gnt_n, s_cmd_mwi, s_first_data_done, io_req_valid;
  logic [31:0] io_req_addr;
  logic psel, penable, pwrite, pready, pslverr, rd_done, rd_err, to_seen;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd_data;
  logic [3:0] pstrb;
  logic p_tenure_expired, s_tenure_expired, s_end_now, io_hit_valid, io_fwd_hit;
  logic [7:0] up_bus_index, down_bus_index, highest_bus_index;
  logic [32:0] exp_q[$];
  logic hit_q[$];
  int err_total = 0;
  int compares = 0;
  int seed = 32'hd32c;

  always #20 pclk = ~pclk;

  bbr_host_model i_bbr_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rd_done, .rd_data, .rd_err, .to_seen);
  bbr_regs i_bbr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .p_frame_start, .p_master_active, .p_tenure_expired,
    .s_frame_start, .s_master_active, .s_gnt_n, .s_cmd_mwi, .s_first_data_done,
    .s_tenure_expired, .s_end_now, .io_req_valid, .io_req_addr, .io_hit_valid, .io_fwd_hit,
    .up_bus_index, .down_bus_index, .highest_bus_index);

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (exp_q.size() != 0 || hit_q.size() != 0) err_total++;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_resp(input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic check_bit(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // expected {pslverr, prdata} is noted before the transfer goes out
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [32:0] e);
    exp_q.push_back(e);
    i_bbr_host_model.xfer(wr, a, d, s);
  endtask
  task automatic run_tenure(input logic sec, input int n);
    s_frame_start <= sec;
    s_master_active <= sec;
    p_frame_start <= !sec;
    p_master_active <= !sec;
    @(posedge pclk);
    s_frame_start <= 1'b0;
    p_frame_start <= 1'b0;
    repeat (n) @(negedge pclk);
    check_bit(1'b0, sec ? s_tenure_expired : p_tenure_expired);
    @(negedge pclk);
    check_bit(1'b1, sec ? s_tenure_expired : p_tenure_expired);
    @(posedge pclk);
    s_master_active <= 1'b0;
    p_master_active <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (rd_done === 1'b1) check_resp(exp_q.pop_front(), {rd_err, rd_data});
    if (io_hit_valid === 1'b1) check_bit(hit_q.pop_front(), io_fwd_hit);
    if (to_seen === 1'b1) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic [31:0] a;
    logic [31:0] lo;
    logic [31:0] hi;
    {p_frame_start, p_master_active, s_frame_start, s_master_active} = 4'h0;
    {s_gnt_n, s_cmd_mwi, s_first_data_done, io_req_valid} = 4'h0;
    io_req_addr = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rw(1'b0, OFS_LAT_HDR, 32'h0, 4'h0, {1'b0, 32'h0001_0000});
    rw(1'b0, OFS_BUS_NUM, 32'h0, 4'h0, 33'h0);
    rw(1'b0, OFS_IO_WIN, 32'h0, 4'h0, {1'b0, 32'h0000_0101});
    rw(1'b0, OFS_IO_UPPER, 32'h0, 4'h0, 33'h0);
    rw(1'b1, OFS_LAT_HDR, 32'hFFFF_FFFF, 4'hF, 33'h0);
    rw(1'b0, OFS_LAT_HDR, 32'h0, 4'h0, {1'b0, 32'h0001_FF00});
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      rw(1'b1, OFS_BUS_NUM, r, 4'hF, 33'h0);
      rw(1'b1, OFS_BUS_NUM, ~r, 4'h2, 33'h0);
      rw(1'b0, OFS_BUS_NUM, 32'h0, 4'h0, {1'b0, r[31:16], ~r[15:8], r[7:0]});
      // the bus numbers also leave the block on their own ports
      check_resp({9'h000, r[23:16], ~r[15:8], r[7:0]},
                 {9'h000, highest_bus_index, down_bus_index, up_bus_index});
    end
    rw(1'b1, OFS_IO_WIN, 32'hFFFF_FFFF, 4'hF, 33'h0);
    rw(1'b0, OFS_IO_WIN, 32'h0, 4'h0, {1'b0, 32'h0000_F1F1});
    rw(1'b0, 8'h44, 32'h0, 4'h0, {1'b1, 32'h0});
    rw(1'b1, OFS_STATUS, 32'h0, 4'hF, {1'b1, 32'h0});
    rw(1'b1, OFS_IO_WIN, 32'h0000_5030, 4'hF, 33'h0);
    rw(1'b1, OFS_IO_UPPER, 32'h0002_0001, 4'hF, 33'h0);
    rw(1'b0, OFS_IO_UPPER, 32'h0, 4'h0, {1'b0, 32'h0002_0001});
    lo = {16'h0001, 4'h3, IO_LOW_FILL};
    hi = {16'h0002, 4'h5, IO_HIGH_FILL};
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      a = (i == 0) ? lo - 32'h1 : (i == 1) ? lo : (i == 2) ? hi : (i == 3) ? hi + 32'h1 : {14'h0, r[17:0]};
      hit_q.push_back(a >= lo && a <= hi);
      io_req_valid <= 1'b1;
      io_req_addr <= a;
      @(posedge pclk);
    end
    io_req_valid <= 1'b0;
    rw(1'b1, OFS_LAT_HDR, 32'h0000_0100, 4'h2, 33'h0);
    run_tenure(1'b0, 1);
    rw(1'b1, OFS_BUS_NUM, 32'h0200_0000, 4'h8, 33'h0);
    run_tenure(1'b1, 2);
    rw(1'b1, OFS_BUS_NUM, 32'h0, 4'h8, 33'h0);
    s_master_active <= 1'b1;
    s_gnt_n <= 1'b1;
    s_first_data_done <= 1'b1;
    repeat (2) @(negedge pclk);
    check_bit(1'b1, s_end_now);
    @(posedge pclk);
    s_cmd_mwi <= 1'b1;
    repeat (2) @(negedge pclk);
    check_bit(1'b0, s_end_now);
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule // tb
